// file: logic/byte_lane_bus_status.sv
`timescale 1ns/100ps
module byte_lane_bus_status (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        ready_i,
	input  wire logic        hold_i,
	output logic             high_enable_status_pin_o,
	output logic             high_enable_status_oe_n_o,
	output logic             address_bit_zero_o,
	output logic             address_bit_zero_oe_n_o,
	output logic      [3:0]  addr_status_o,
	output logic             addr_status_oe_n_o
);
	// ------------------------------------------------------------
	// pin synchronisers: a change counts once stages two and three agree
	// ------------------------------------------------------------
	logic [1:0]                       pins_raw;
	logic [lane_pkg::SYNC_STAGES-1:0] sync_q [2];
	logic [1:0]                       pins_seen;
	logic                             ready_seen;
	logic                             hold_seen;

	assign pins_raw   = {hold_i, ready_i};
	assign ready_seen = pins_seen[0];
	assign hold_seen  = pins_seen[1];

	for (genvar p = 0; p < 2; p++) begin : g_sync
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				sync_q[p]    <= '0;
				pins_seen[p] <= 1'b0;
			end else begin
				sync_q[p] <= {sync_q[p][1:0], pins_raw[p]};
				if (sync_q[p][1] == sync_q[p][2])
					pins_seen[p] <= sync_q[p][2];
			end
		end
	end

	// ------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------
	logic                           ie_flag;
	logic                           s7_value;
	logic [lane_pkg::ADDR_BITS-1:0] addr_reg;
	lane_pkg::cycle_t               cmd_type;
	logic                           cmd_word;
	logic [1:0]                     cmd_seg;
	logic                           pending;
	lane_pkg::bus_state_t           state;
	lane_pkg::bus_state_t           next_state;
	logic                           busy;
	logic                           wr_go;
	logic [31:0]                    next_rdata;

	assign busy  = pending || (state != lane_pkg::bus_idle);
	// writes land on the edge where ack is seen high
	assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (wb_adr_i)
			lane_pkg::OFF_CTRL: begin
				next_rdata[lane_pkg::CTRL_IE_BIT] = ie_flag;
				next_rdata[lane_pkg::CTRL_S7_BIT] = s7_value;
			end
			lane_pkg::OFF_ADDR: next_rdata[lane_pkg::ADDR_BITS-1:0] = addr_reg;
			lane_pkg::OFF_CMD: begin
				next_rdata[lane_pkg::CMD_TYPE_LSB +: 3] = cmd_type;
				next_rdata[lane_pkg::CMD_WORD_BIT]      = cmd_word;
				next_rdata[lane_pkg::CMD_SEG_LSB +: 2]  = cmd_seg;
			end
			lane_pkg::OFF_STAT: begin
				next_rdata[lane_pkg::STAT_BUSY_BIT]     = busy;
				next_rdata[lane_pkg::STAT_HOLD_BIT]     = hold_seen;
				next_rdata[lane_pkg::STAT_READY_BIT]    = ready_seen;
				next_rdata[lane_pkg::STAT_STATE_LSB +: 6] = state;
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
			wb_dat_o <= next_rdata;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ie_flag  <= 1'b0;
			s7_value <= 1'b0;
		end else if (wr_go && wb_adr_i == lane_pkg::OFF_CTRL && wb_sel_i[0]) begin
			ie_flag  <= wb_dat_i[lane_pkg::CTRL_IE_BIT];
			s7_value <= wb_dat_i[lane_pkg::CTRL_S7_BIT];
		end
	end

	// address and command are frozen while a cycle is pending or running
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_reg <= '0;
		end else if (wr_go && wb_adr_i == lane_pkg::OFF_ADDR && !busy) begin
			if (wb_sel_i[0])
				addr_reg[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1])
				addr_reg[15:8] <= wb_dat_i[15:8];
			if (wb_sel_i[2])
				addr_reg[19:16] <= wb_dat_i[19:16];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_type <= lane_pkg::mem_read;
			cmd_word <= 1'b0;
			cmd_seg  <= lane_pkg::SEG_CODE;
			pending  <= 1'b0;
		end else if (wr_go && wb_adr_i == lane_pkg::OFF_CMD && wb_sel_i[0] && !busy) begin
			cmd_type <= lane_pkg::cycle_t'(wb_dat_i[lane_pkg::CMD_TYPE_LSB +: 3]);
			cmd_word <= wb_dat_i[lane_pkg::CMD_WORD_BIT];
			cmd_seg  <= wb_dat_i[lane_pkg::CMD_SEG_LSB +: 2];
			pending  <= 1'b1;
		end else if (next_state == lane_pkg::address_state) begin
			pending <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// bus state sequencer
	// ------------------------------------------------------------
	logic       is_inta;
	logic       is_mem;
	logic [1:0] lane_code;
	logic       enable_t1;
	logic       status_next;

	assign is_inta = (cmd_type == lane_pkg::inta_one) || (cmd_type == lane_pkg::inta_two);
	assign is_mem  = (cmd_type == lane_pkg::mem_read) || (cmd_type == lane_pkg::mem_write);

	// a word at an odd address cannot use both lanes; only the upper lane moves
	always_comb begin
		if (addr_reg[0])
			lane_code = lane_pkg::LANE_UPPER; // [RULE_06]
		else if (cmd_word)
			lane_code = lane_pkg::LANE_WORD; // [RULE_02] [RULE_08]
		else
			lane_code = lane_pkg::LANE_LOWER; // [RULE_06]
	end

	assign enable_t1 = (cmd_type == lane_pkg::inta_one) ? 1'b0 : lane_code[1]; // [RULE_03]

	always_comb begin
		next_state = state;
		unique case (state)
			lane_pkg::bus_idle:
				if (pending && !hold_seen)
					next_state = lane_pkg::address_state;
			lane_pkg::address_state:   next_state = lane_pkg::second_bus_state;
			lane_pkg::second_bus_state: next_state = lane_pkg::third_bus_state;
			lane_pkg::third_bus_state:
				next_state = ready_seen ? lane_pkg::final_bus_state : lane_pkg::wait_bus_state;
			lane_pkg::wait_bus_state:
				if (ready_seen)
					next_state = lane_pkg::final_bus_state;
			lane_pkg::final_bus_state: next_state = lane_pkg::bus_idle;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			state <= lane_pkg::bus_idle;
		else
			state <= next_state;
	end

	assign status_next = !(next_state == lane_pkg::bus_idle || next_state == lane_pkg::address_state);

	// ------------------------------------------------------------
	// pin outputs, registered so they line up with the state they belong to
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			high_enable_status_pin_o  <= 1'b1;
			high_enable_status_oe_n_o <= 1'b1;
			address_bit_zero_o        <= 1'b0;
			address_bit_zero_oe_n_o   <= 1'b1;
			addr_status_o             <= 4'h0;
			addr_status_oe_n_o        <= 1'b1;
		end else if (next_state == lane_pkg::address_state) begin
			high_enable_status_pin_o  <= enable_t1; // [RULE_02] [RULE_03] [RULE_06]
			high_enable_status_oe_n_o <= 1'b0;
			address_bit_zero_o        <= addr_reg[0]; // [RULE_08]
			// the low lanes float for interrupt acknowledge
			address_bit_zero_oe_n_o   <= is_inta;
			addr_status_o             <= is_mem ? addr_reg[19:16] : 4'h0;
			addr_status_oe_n_o        <= 1'b0;
		end else if (status_next) begin
			high_enable_status_pin_o  <= s7_value; // [RULE_04]
			high_enable_status_oe_n_o <= 1'b0;
			address_bit_zero_oe_n_o   <= 1'b1;
			// ie_flag sampled every clock in the status states
			addr_status_o             <= {1'b0, ie_flag, is_inta ? lane_pkg::SEG_CODE : cmd_seg}; // [RULE_01] [RULE_09] [RULE_10] [RULE_11]
			addr_status_oe_n_o        <= 1'b0;
		end else begin
			high_enable_status_pin_o  <= 1'b1;
			high_enable_status_oe_n_o <= hold_seen; // [RULE_05]
			address_bit_zero_oe_n_o   <= 1'b1;
			addr_status_o             <= 4'h0;
			addr_status_oe_n_o        <= hold_seen; // [RULE_05]
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	logic in_status;
	assign in_status = !(state == lane_pkg::bus_idle || state == lane_pkg::address_state);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_status_six_low: assert property (in_status |-> !addr_status_o[3] && !addr_status_oe_n_o) // [RULE_11]
		else $error("status bit six not low in status state");

	a_segment_code: assert property (in_status && !is_inta |-> addr_status_o[1:0] == cmd_seg) // [RULE_01]
		else $error("segment code wrong");

	a_hold_float: assert property (state == lane_pkg::bus_idle && $past(hold_seen) // [RULE_05]
		|-> high_enable_status_oe_n_o && addr_status_oe_n_o)
		else $error("pins driven while bus held");

	a_upper_lane: assert property (state == lane_pkg::address_state && (cmd_word || addr_reg[0]) // [RULE_02]
		|-> !high_enable_status_pin_o && !high_enable_status_oe_n_o)
		else $error("high enable not low for upper lane");

	a_inta_enable: assert property (state == lane_pkg::address_state && cmd_type == lane_pkg::inta_one // [RULE_03]
		|-> !high_enable_status_pin_o)
		else $error("high enable not low in first acknowledge");

	a_seven_phase: assert property (in_status |-> high_enable_status_pin_o == $past(s7_value)) // [RULE_04]
		else $error("shared pin not carrying status bit seven");

	a_lower_lane: assert property (state == lane_pkg::address_state && !is_inta && !addr_reg[0] // [RULE_08]
		|-> !address_bit_zero_o && !address_bit_zero_oe_n_o)
		else $error("address bit zero not low for lower lane");

	a_width_code: assert property (state == lane_pkg::address_state && !is_inta // [RULE_06]
		|-> {high_enable_status_pin_o, address_bit_zero_o} == {!(cmd_word || addr_reg[0]), addr_reg[0]})
		else $error("lane code does not match transfer width");

	a_ie_refresh: assert property (in_status && $past(in_status) |-> addr_status_o[2] == $past(ie_flag)) // [RULE_10]
		else $error("interrupt enable status stale");

	a_status_phase: assert property (state == lane_pkg::address_state // [RULE_09]
		|=> state == lane_pkg::second_bus_state ##1 state == lane_pkg::third_bus_state)
		else $error("status phase sequence broken");

	a_io_upper_low: assert property (state == lane_pkg::address_state && !is_mem // [RULE_09]
		|-> addr_status_o == 4'h0)
		else $error("upper address lines not low outside memory cycles");

	a_mem_upper_addr: assert property (state == lane_pkg::address_state && is_mem // [RULE_09]
		|-> addr_status_o == addr_reg[19:16])
		else $error("upper address lines not carrying address");

	a_status_driven: assert property (in_status // [RULE_04]
		|-> !high_enable_status_oe_n_o && address_bit_zero_oe_n_o)
		else $error("shared pin not driven in status state");

	// a held bus must keep the sequencer parked; a late start is the safe side
	a_hold_delay: assert property (state == lane_pkg::bus_idle && hold_seen // [RULE_05]
		|=> state == lane_pkg::bus_idle)
		else $error("bus cycle started while held");

	a_idle_quiet: assert property (state == lane_pkg::bus_idle // [RULE_05]
		|-> high_enable_status_pin_o && address_bit_zero_oe_n_o && addr_status_o == 4'h0)
		else $error("pins not quiet between cycles");

	a_inta_float: assert property (state == lane_pkg::address_state && is_inta // [RULE_08]
		|-> address_bit_zero_oe_n_o)
		else $error("address bit zero driven in acknowledge");

	// ack is a strict one-cycle pulse, so a master never sees one answer twice
	a_ack_pulse: assert property (wb_ack_o
		|=> !wb_ack_o)
		else $error("ack held longer than one cycle");
endmodule

// file: logic/lane_pkg.sv
// Contract
// RULE_01 - status lines 1:0 give segment: 00 alt data, 01 stack, 10 code, 11 data
// RULE_02 - in address state drive high_byte_enable_n low when upper lanes carry a byte
// RULE_03 - high_byte_enable_n low in address state of first interrupt acknowledge
// RULE_04 - shared pin carries status_bit_seven in second, third and final states
// RULE_05 - high enable pin is active low and floats while bus is held
// RULE_06 - enable/address_bit_zero: 00 word, 01 upper odd, 10 lower even, 11 none
// RULE_07 - upper-lane eight-bit peripherals should qualify chip select with latched enable
// RULE_08 - in address state drive address_bit_zero low when lower lanes carry a byte
// RULE_09 - upper four address lines carry status in second, third, wait, final states
// RULE_10 - interrupt enable status bit is refreshed on every clock
// RULE_11 - status_bit_six is low in the status states of every cycle
package lane_pkg;
	// ------------------------------------------------------------
	// register map (byte offsets, one word each)
	// ------------------------------------------------------------
	localparam logic [3:0] OFF_CTRL       = 4'h0;
	localparam logic [3:0] OFF_ADDR       = 4'h4;
	localparam logic [3:0] OFF_CMD        = 4'h8;
	localparam logic [3:0] OFF_STAT       = 4'hc;
	localparam int         CTRL_IE_BIT    = 0;
	localparam int         CTRL_S7_BIT    = 1;
	localparam int         CMD_TYPE_LSB   = 0;
	localparam int         CMD_WORD_BIT   = 3;
	localparam int         CMD_SEG_LSB    = 4;
	localparam int         STAT_BUSY_BIT  = 0;
	localparam int         STAT_HOLD_BIT  = 1;
	localparam int         STAT_READY_BIT = 2;
	localparam int         STAT_STATE_LSB = 8;
	localparam int         ADDR_BITS      = 20;
	localparam int         SYNC_STAGES    = 3;
	localparam logic [1:0] SEG_CODE       = 2'h2;
	localparam logic [1:0] LANE_WORD      = 2'h0;
	localparam logic [1:0] LANE_UPPER     = 2'h1;
	localparam logic [1:0] LANE_LOWER     = 2'h2;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		mem_read  = 3'h0,
		mem_write = 3'h1,
		io_read   = 3'h2,
		io_write  = 3'h3,
		inta_one  = 3'h4,
		inta_two  = 3'h5
	} cycle_t;

	typedef enum logic [5:0] {
		bus_idle         = 6'h01,
		address_state    = 6'h02,
		second_bus_state = 6'h04,
		third_bus_state  = 6'h08,
		wait_bus_state   = 6'h10,
		final_bus_state  = 6'h20
	} bus_state_t;
endpackage

// file: tb/bus_partner.sv
`timescale 1ns/100ps
module bus_partner (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] waits_i,
	input  wire logic       hold_req_i,
	input  wire logic       pin_i,
	input  wire logic       a0_oe_n_i,
	output logic            ready_o,
	output logic            hold_o,
	output logic            upper_cs_o
);
	// ----------------------------------------
	// slow memory with a hold requester
	// ----------------------------------------
	logic [3:0] count;
	logic [3:0] waits_q;
	assign hold_o  = hold_req_i;
	assign ready_o = (count == 4'h0);
	// reload on a new wait setting too, so ready is already low when the cycle starts
	always_ff @(posedge clk_i) begin
		waits_q <= waits_i;
		if (rst_i) begin
			count      <= 4'h0;
			upper_cs_o <= 1'b0;
		end else if (!a0_oe_n_i || waits_i != waits_q) begin
			count      <= waits_i;
			upper_cs_o <= !a0_oe_n_i ? !pin_i : upper_cs_o;
		end else if (count != 4'h0) begin
			count <= count - 4'h1;
		end
	end
endmodule

// file: tb/tb.sv
`timescale 1ns/100ps
module tb;
	logic        clk_i, rst_i, cyc, stb, we, ready, hold, hold_req, pin, pin_oe_n, a0, a0_oe_n, st_oe_n, ack;
	logic        upper_cs;
	logic [3:0]  adr, sel, st, waits;
	logic [31:0] dat, dat_o, q;
	int          n_errors, check_count, cycles;

	byte_lane_bus_status byte_lane_bus_status_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.ready_i(ready), .hold_i(hold), .high_enable_status_pin_o(pin), .high_enable_status_oe_n_o(pin_oe_n),
		.address_bit_zero_o(a0), .address_bit_zero_oe_n_o(a0_oe_n), .addr_status_o(st),
		.addr_status_oe_n_o(st_oe_n));
	bus_partner bus_partner_i (.clk_i(clk_i), .rst_i(rst_i), .waits_i(waits), .hold_req_i(hold_req),
		.pin_i(pin), .a0_oe_n_i(a0_oe_n), .ready_o(ready), .hold_o(hold), .upper_cs_o(upper_cs));

	// ----------------------------------------
	// bus access and checking
	// ----------------------------------------
	task automatic close_out();
		if (n_errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wait_idle();
		q = 32'h1;
		for (int i = 0; i < 60 && q[0] !== 1'b0; i++)
			xfer(1'b0, lane_pkg::OFF_STAT, 32'h0);
		chk(q[0], 1'b0);
		chk(st, 4'h0);
	endtask

	task automatic run(input logic [2:0] t, input logic w, input logic [1:0] sg, input logic [19:0] ad,
		input logic ie, input logic s7);
		logic [1:0] ln;
		ln = w ? {1'b0, ad[0]} : (ad[0] ? 2'h1 : 2'h2);
		xfer(1'b1, lane_pkg::OFF_CTRL, {30'h0, s7, ie});
		xfer(1'b1, lane_pkg::OFF_ADDR, {12'h0, ad});
		xfer(1'b1, lane_pkg::OFF_CMD, {26'h0, sg, w, t});
		@(posedge clk_i);
		#1;
		if (t < 3'h4) begin
			chk({pin, a0, a0_oe_n}, {ln, 1'b0});
			chk(st, t < 3'h2 ? ad[19:16] : 4'h0);
		end else begin
			chk({pin, a0_oe_n}, {(t == 3'h4) ? 1'b0 : ln[1], 1'b1});
		end
		@(posedge clk_i);
		#1;
		chk(st, {1'b0, ie, t > 3'h3 ? 2'h2 : sg});
		chk({pin, a0_oe_n}, {s7, 1'b1});
		if (t < 3'h4)
			chk(upper_cs, !ln[1]);
		wait_idle();
	endtask

	// ----------------------------------------
	// clock, watchdog and test sequence
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			n_errors++;
			close_out();
		end
	end

	initial begin
		{rst_i, cyc, stb, we, hold_req, adr, waits, dat, n_errors, check_count, cycles} = '0;
		rst_i = 1'b1;
		sel   = 4'hf;
		repeat (8) @(posedge clk_i);
		chk({pin, pin_oe_n, a0_oe_n, st_oe_n, st}, 8'hf0);
		rst_i <= 1'b0;
		for (int i = 0; i < 6; i++)
			run(3'(i), i % 3 == 0, 2'(i), 20'h95432 + 20'(i), i[0], i[1]);
		xfer(1'b0, 4'h2, 32'h0);
		chk(q, 32'h0);
		waits <= 4'hc;
		run(3'h0, 1'b0, 2'h3, 20'h10000, 1'b1, 1'b1);
		// a changed wait count reloads the partner, so ready is low before this cycle starts
		waits <= 4'hb;
		xfer(1'b1, lane_pkg::OFF_CTRL, 32'h3);
		xfer(1'b1, lane_pkg::OFF_CMD, 32'h30);
		repeat (2) @(posedge clk_i);
		xfer(1'b1, lane_pkg::OFF_CTRL, 32'h2);
		@(posedge clk_i);
		#1;
		chk(st, 4'h3);
		xfer(1'b0, lane_pkg::OFF_STAT, 32'h0);
		chk(q[13:8], 6'h10);
		waits <= 4'h0;
		wait_idle();
		hold_req <= 1'b1;
		repeat (6) @(posedge clk_i);
		#1;
		chk({pin_oe_n, st_oe_n}, 2'h3);
		xfer(1'b1, lane_pkg::OFF_CMD, 32'h0);
		repeat (10) @(posedge clk_i);
		xfer(1'b0, lane_pkg::OFF_STAT, 32'h0);
		chk({q[13:8], q[1:0]}, 8'h07);
		hold_req <= 1'b0;
		wait_idle();
		close_out();
	end
endmodule
